// File: verilog/gncu_map.svh
// Constants of the gain normalization command unit: APB offsets,
// command and status fields, defaults, limits and fixed-point scale.
// Assumes an 8-bit APB byte address and 32-bit data.
`ifndef GNCU_MAP_SVH
`define GNCU_MAP_SVH

// APB byte offsets
`define GNCU_ADDR_CMD      8'h00
`define GNCU_ADDR_CONFIG   8'h04
`define GNCU_ADDR_STATUS   8'h08
`define GNCU_ADDR_RSENS    8'h0c
`define GNCU_ADDR_RLEVEL   8'h10
`define GNCU_ADDR_REXPECT  8'h14
`define GNCU_ADDR_RGAIN    8'h18

// Command word fields
`define GNCU_CMD_OP_MSB    30
`define GNCU_CMD_OP_LSB    28
`define GNCU_CMD_CH_MSB    20
`define GNCU_CMD_CH_LSB    16
`define GNCU_CMD_VAL_MSB   13
`define GNCU_CMD_VAL_LSB   0

// Status word fields
`define GNCU_STAT_BUSY     0
`define GNCU_STAT_RES_MSB  6
`define GNCU_STAT_RES_LSB  4

// Channel and value limits
`define GNCU_LAST_CHAN     5'h10
`define GNCU_VALUE_MAX     14'h270f
`define GNCU_LEVEL_MIN     14'h0001
`define GNCU_LEVEL_MAX     14'h000a

// Defaults: 1000.0 mV/unit in tenths, 1 V/unit, 1 unit, gain 1.0
`define GNCU_DEF_SENS      14'h2710
`define GNCU_DEF_LEVEL     4'h1
`define GNCU_DEF_EXPECT    14'h0001
`define GNCU_DEF_GAIN      21'h002710

// Gain is held times 10000; numerator is level times 1e8
`define GNCU_NUM_SCALE     30'h05f5e100
`define GNCU_GAIN_MIN_STD  30'h000003e8
`define GNCU_GAIN_MIN_EXT  30'h00000019
`define GNCU_GAIN_MAX      30'h001e8480

// Strap settle time after reset release, in cycles
`define GNCU_BOOT_WAIT     2'h3

`endif

// File: verilog/gncu_pkg.sv
// Types of the gain normalization command unit.
// Assumes gncu_map.svh for all numeric constants.
package gncu_pkg;

  typedef enum logic [2:0]
  {
    OP_NONE  = 3'b000,
    OP_SETN  = 3'b001,
    OP_SETE  = 3'b010,
    OP_QRYN  = 3'b011,
    OP_QRYE  = 3'b100
  } gncu_op_type;

  typedef enum logic [2:0]
  {
    RES_NONE  = 3'b000,
    RES_OK    = 3'b001,
    RES_RANGE = 3'b010,
    RES_BADCH = 3'b011,
    RES_QUERY = 3'b100
  } gncu_result_type;

  typedef enum logic [3:0]
  {
    S_BOOT    = 4'b0000,
    S_DEFLT   = 4'b0001,
    S_IDLE    = 4'b0010,
    S_CHECK   = 4'b0011,
    S_LVLRD   = 4'b0100,
    S_LVLGET  = 4'b0101,
    S_CHRD    = 4'b0110,
    S_CHGET   = 4'b0111,
    S_DIVWAIT = 4'b1000,
    S_LVLWR   = 4'b1001
  } gncu_state_type;

  typedef struct packed
  {
    logic [3:0]  level;
    logic [13:0] sens;
    logic [13:0] expIn;
    logic [20:0] gain;
  } gncu_word_type;

  typedef struct packed
  {
    logic        busy;
    logic        done;
    logic [4:0]  count;
    logic [27:0] rem;
    logic [29:0] quo;
  } gncu_div_type;

  typedef struct packed
  {
    gncu_state_type  state;
    logic [1:0]      waitCnt;
    logic [4:0]      idx;
    gncu_op_type     op;
    logic [4:0]      chan;
    logic [13:0]     value;
    logic            checkPass;
    logic [3:0]      newLevel;
    gncu_word_type   word;
    logic            busy;
    gncu_result_type result;
    logic            extRange;
    gncu_word_type   reply;
    logic            sync1;
    logic            sync2;
    logic            sync3;
    logic            fitted;
    logic            memWe;
    logic [4:0]      rdAddr;
    logic [4:0]      wrAddr;
    gncu_word_type   wrData;
    logic            divStart;
    logic [31:0]     prdata;
    logic            pready;
    logic            pslverr;
  } gncu_main_type;

endpackage

// File: verilog/gncu_store.sv
// Per-channel settings store, slot 0 holds the rack output level.
// Contents survive sys_rst, standing for the non-volatile memory;
// read data come out of a register one cycle after the address.
`timescale 1ns/1ps
`default_nettype none

module gncu_store
(
  input  wire logic                   mclk,
  input  wire logic                   we,
  input  wire logic [4:0]             wrAddr,
  input  wire gncu_pkg::gncu_word_type wrData,
  input  wire logic [4:0]             rdAddr,
  output var gncu_pkg::gncu_word_type rdData
);

  gncu_pkg::gncu_word_type mem [0:16];

  always_ff @(posedge mclk)
  begin
    if (we)
    begin
      mem[wrAddr] <= wrData;
    end
    rdData <= mem[rdAddr];
  end

endmodule

`default_nettype wire

// File: verilog/gncu_divider.sv
// Sequential restoring divider, one quotient bit per clock.
// A start pulse loads the dividend, the divisor is read every cycle; done pulses 31 cycles later.
// A zero divisor yields an all-ones quotient.
`timescale 1ns/1ps
`default_nettype none

module gncu_divider
(
  input  wire logic        mclk,
  input  wire logic        sys_rst,
  input  wire logic        start,
  input  wire logic [29:0] numer,
  input  wire logic [27:0] denom,
  output logic             done,
  output logic [29:0]      quot
);

  gncu_pkg::gncu_div_type r;
  gncu_pkg::gncu_div_type next_r;
  logic [28:0]            trial;

  always_comb
  begin
    next_r = r;
    next_r.done = 1'b0;
    trial = {r.rem, r.quo[29]};
    if (start)
    begin
      next_r.busy = 1'b1;
      next_r.count = 5'h00;
      next_r.rem = 28'h0000000;
      next_r.quo = numer;
    end
    else if (r.busy)
    begin
      if (trial >= {1'b0, denom})
      begin
        next_r.rem = 28'(trial - {1'b0, denom});
        next_r.quo = {r.quo[28:0], 1'b1};
      end
      else
      begin
        next_r.rem = trial[27:0];
        next_r.quo = {r.quo[28:0], 1'b0};
      end
      next_r.count = 5'(r.count + 5'h01);
      if (r.count == 5'h1d)
      begin
        next_r.busy = 1'b0;
        next_r.done = 1'b1;
      end
    end
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      r <= '0;
    end
    else
    begin
      r <= next_r;
    end
  end

  assign done = r.done;
  assign quot = r.quo;

endmodule

`default_nettype wire

// File: verilog/gncu_top.sv
// Gain normalization command unit: takes parsed sensitivity, output
// level and expected-input commands over APB, computes each channel's
// gain, checks it and reports acceptance, errors or stored values.
// Assumes a host that parses the ASCII text and an APB master.
//
// Notes on behaviour
// - A sensitivity command names channel 1 to 16, stores its sensitivity and recomputes its gain.
// - Sensitivity is given in tenths of a millivolt per unit, up to 999.9.
// - A sensitivity command to channel zero sets the rack output level for all channels.
// - The rack output level is a whole number of volts per unit from 1 to 10.
// - Gain is output level over sensitivity times expected input, scaled mV to V.
// - Gain must lie in 0.1 to 200, or 0.0025 to 200 with the extended range.
// - An accepted request updates the affected gains and reports success.
// - A gain outside the limits reports an out-of-range error.
// - A sensitivity query reports the channel's sensitivity and the output level.
// - An expected-input command names channel 1 to 16 and stores its expected input.
// - An expected-input query reports sensitivity, output level and expected input.
// - Defaults are 1000 mV/unit, 1 V/unit and 1 unit.
// - With the memory fitted, all settings and gains survive reset.
// - Without the memory, defaults are loaded at every reset.
//
// Design decisions made here: the register addresses and register access over APB.
`include "gncu_map.svh"
`timescale 1ns/1ps
`default_nettype none

module gncu_top
(
  input  wire logic        mclk,
  input  wire logic        sys_rst,
  input  wire logic        memOptionFitted,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr
);

  gncu_pkg::gncu_main_type r;
  gncu_pkg::gncu_main_type next_r;
  gncu_pkg::gncu_word_type rdWord;
  gncu_pkg::gncu_word_type defWord;
  logic                    divDone;
  logic [29:0]             divQuot;
  logic [29:0]             divNumer;
  logic [27:0]             divDenom;
  logic [29:0]             gainMin;
  logic                    gainOk;
  logic                    apbAccess;
  gncu_pkg::gncu_op_type   cmdOp;
  logic [4:0]              cmdChan;
  logic [13:0]             cmdValue;

  assign divNumer = 30'(r.newLevel * `GNCU_NUM_SCALE);
  assign divDenom = r.word.sens * r.word.expIn;

  assign gainMin = r.extRange ? `GNCU_GAIN_MIN_EXT : `GNCU_GAIN_MIN_STD;
  assign gainOk = (divQuot >= gainMin) && (divQuot <= `GNCU_GAIN_MAX);

  assign apbAccess = psel && penable && !r.pready;
  assign cmdOp = gncu_pkg::gncu_op_type'(pwdata[`GNCU_CMD_OP_MSB:`GNCU_CMD_OP_LSB]);
  assign cmdChan = pwdata[`GNCU_CMD_CH_MSB:`GNCU_CMD_CH_LSB];
  assign cmdValue = pwdata[`GNCU_CMD_VAL_MSB:`GNCU_CMD_VAL_LSB];

  assign defWord = '{level: `GNCU_DEF_LEVEL, sens: `GNCU_DEF_SENS,
                     expIn: `GNCU_DEF_EXPECT, gain: `GNCU_DEF_GAIN};

  gncu_store u_store
  (
    .mclk   (mclk),
    .we     (r.memWe),
    .wrAddr (r.wrAddr),
    .wrData (r.wrData),
    .rdAddr (r.rdAddr),
    .rdData (rdWord)
  );

  gncu_divider u_divider
  (
    .mclk    (mclk),
    .sys_rst (sys_rst),
    .start   (r.divStart),
    .numer   (divNumer),
    .denom   (divDenom),
    .done    (divDone),
    .quot    (divQuot)
  );

  always_comb
  begin
    next_r = r;
    next_r.memWe = 1'b0;
    next_r.divStart = 1'b0;
    next_r.pready = 1'b0;
    next_r.pslverr = 1'b0;
    // Memory-option strap synchroniser
    next_r.sync1 = memOptionFitted;
    next_r.sync2 = r.sync1;
    next_r.sync3 = r.sync2;
    if (r.sync2 == r.sync3)
    begin
      next_r.fitted = r.sync3;
    end

    case (r.state)
      gncu_pkg::S_BOOT:
      begin
        next_r.waitCnt = 2'(r.waitCnt + 2'h1);
        if (r.waitCnt == `GNCU_BOOT_WAIT)
        begin
          next_r.idx = 5'h00;
          // keep stored settings
          // Filtered strap of this cycle, the register lags by one
          if (next_r.fitted)
          begin
            next_r.state = gncu_pkg::S_IDLE;
          end
          else
          begin
            next_r.state = gncu_pkg::S_DEFLT;
          end
        end
      end
      gncu_pkg::S_DEFLT:
      begin
        next_r.memWe = 1'b1;
        next_r.wrAddr = r.idx;
        next_r.wrData = defWord;
        next_r.idx = 5'(r.idx + 5'h01);
        if (r.idx == `GNCU_LAST_CHAN)
        begin
          next_r.state = gncu_pkg::S_IDLE;
        end
      end
      gncu_pkg::S_IDLE:
      begin
        next_r.busy = 1'b0;
      end
      gncu_pkg::S_CHECK:
      begin
        next_r.state = gncu_pkg::S_IDLE;
        next_r.busy = 1'b0;
        if (r.chan > `GNCU_LAST_CHAN || r.op == gncu_pkg::OP_NONE ||
            r.op > gncu_pkg::OP_QRYE ||
            (r.chan == 5'h00 && r.op != gncu_pkg::OP_SETN &&
             r.op != gncu_pkg::OP_QRYN))
        begin
          next_r.result = gncu_pkg::RES_BADCH;
        end
        else if (r.op == gncu_pkg::OP_SETN && r.chan == 5'h00 &&
                 (r.value < `GNCU_LEVEL_MIN || r.value > `GNCU_LEVEL_MAX))
        begin
          next_r.result = gncu_pkg::RES_RANGE;
        end
        else if (r.value > `GNCU_VALUE_MAX)
        begin
          next_r.result = gncu_pkg::RES_RANGE;
        end
        else
        begin
          next_r.busy = 1'b1;
          next_r.rdAddr = 5'h00;
          next_r.state = gncu_pkg::S_LVLRD;
        end
      end
      gncu_pkg::S_LVLRD:
      begin
        next_r.state = gncu_pkg::S_LVLGET;
      end
      gncu_pkg::S_LVLGET:
      begin
        next_r.state = gncu_pkg::S_CHRD;
        if (r.chan == 5'h00 && r.op == gncu_pkg::OP_QRYN)
        begin
          next_r.reply = rdWord;
          next_r.result = gncu_pkg::RES_QUERY;
          next_r.busy = 1'b0;
          next_r.state = gncu_pkg::S_IDLE;
        end
        else if (r.chan == 5'h00)
        begin
          next_r.newLevel = r.value[3:0];
          next_r.checkPass = 1'b1;
          next_r.idx = 5'h01;
          next_r.rdAddr = 5'h01;
        end
        else
        begin
          next_r.newLevel = rdWord.level;
          next_r.idx = r.chan;
          next_r.rdAddr = r.chan;
        end
      end
      gncu_pkg::S_CHRD:
      begin
        next_r.state = gncu_pkg::S_CHGET;
      end
      gncu_pkg::S_CHGET:
      begin
        next_r.word = rdWord;
        if (r.op == gncu_pkg::OP_QRYN || r.op == gncu_pkg::OP_QRYE)
        begin
          next_r.reply = rdWord;
          next_r.reply.level = r.newLevel;
          next_r.result = gncu_pkg::RES_QUERY;
          next_r.busy = 1'b0;
          next_r.state = gncu_pkg::S_IDLE;
        end
        else
        begin
          if (r.op == gncu_pkg::OP_SETN && r.chan != 5'h00)
          begin
            next_r.word.sens = r.value;
          end
          if (r.op == gncu_pkg::OP_SETE)
          begin
            next_r.word.expIn = r.value;
          end
          next_r.word.level = r.newLevel;
          next_r.divStart = 1'b1;
          next_r.state = gncu_pkg::S_DIVWAIT;
        end
      end
      gncu_pkg::S_DIVWAIT:
      begin
        if (divDone)
        begin
          if (!gainOk)
          begin
            next_r.result = gncu_pkg::RES_RANGE;
            next_r.busy = 1'b0;
            next_r.state = gncu_pkg::S_IDLE;
          end
          else if (r.checkPass)
          begin
            next_r.idx = 5'(r.idx + 5'h01);
            next_r.rdAddr = 5'(r.idx + 5'h01);
            next_r.state = gncu_pkg::S_CHRD;
            if (r.idx == `GNCU_LAST_CHAN)
            begin
              next_r.checkPass = 1'b0;
              next_r.idx = 5'h01;
              next_r.rdAddr = 5'h01;
            end
          end
          else
          begin
            next_r.memWe = 1'b1;
            next_r.wrAddr = r.idx;
            next_r.wrData = r.word;
            next_r.wrData.gain = divQuot[20:0];
            next_r.reply = next_r.wrData;
            if (r.chan != 5'h00)
            begin
              next_r.result = gncu_pkg::RES_OK;
              next_r.busy = 1'b0;
              next_r.state = gncu_pkg::S_IDLE;
            end
            else if (r.idx == `GNCU_LAST_CHAN)
            begin
              next_r.state = gncu_pkg::S_LVLWR;
            end
            else
            begin
              next_r.idx = 5'(r.idx + 5'h01);
              next_r.rdAddr = 5'(r.idx + 5'h01);
              next_r.state = gncu_pkg::S_CHRD;
            end
          end
        end
      end
      gncu_pkg::S_LVLWR:
      begin
        next_r.memWe = 1'b1;
        next_r.wrAddr = 5'h00;
        next_r.wrData = defWord;
        next_r.wrData.level = r.newLevel;
        next_r.result = gncu_pkg::RES_OK;
        next_r.busy = 1'b0;
        next_r.state = gncu_pkg::S_IDLE;
      end
      default:
      begin
        next_r.state = gncu_pkg::S_IDLE;
      end
    endcase

    // APB slave, one wait state on every access
    if (apbAccess)
    begin
      next_r.pready = 1'b1;
      next_r.prdata = 32'h00000000;
      if (pwrite)
      begin
        if (paddr == `GNCU_ADDR_CMD)
        begin
          if (r.state != gncu_pkg::S_IDLE)
          begin
            next_r.pslverr = 1'b1;
          end
          else
          begin
            next_r.op = cmdOp;
            next_r.chan = cmdChan;
            next_r.value = cmdValue;
            next_r.checkPass = 1'b0;
            next_r.busy = 1'b1;
            next_r.result = gncu_pkg::RES_NONE;
            next_r.state = gncu_pkg::S_CHECK;
          end
        end
        else if (paddr == `GNCU_ADDR_CONFIG)
        begin
          next_r.extRange = pwdata[0];
        end
        else
        begin
          next_r.pslverr = 1'b1;
        end
      end
      else if (paddr == `GNCU_ADDR_CONFIG)
      begin
        next_r.prdata = {31'h00000000, r.extRange};
      end
      else if (paddr == `GNCU_ADDR_STATUS)
      begin
        next_r.prdata[`GNCU_STAT_BUSY] = r.busy;
        next_r.prdata[`GNCU_STAT_RES_MSB:`GNCU_STAT_RES_LSB] = r.result;
      end
      else if (paddr == `GNCU_ADDR_RSENS)
      begin
        next_r.prdata = {18'h00000, r.reply.sens};
      end
      else if (paddr == `GNCU_ADDR_RLEVEL)
      begin
        next_r.prdata = {28'h0000000, r.reply.level};
      end
      else if (paddr == `GNCU_ADDR_REXPECT)
      begin
        next_r.prdata = {18'h00000, r.reply.expIn};
      end
      else if (paddr == `GNCU_ADDR_RGAIN)
      begin
        next_r.prdata = {11'h000, r.reply.gain};
      end
      else
      begin
        next_r.pslverr = 1'b1;
      end
    end
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      r <= '0;
    end
    else
    begin
      r <= next_r;
    end
  end

  assign prdata = r.prdata;
  assign pready = r.pready;
  assign pslverr = r.pslverr;

endmodule

`default_nettype wire

// File: bench/gncu_props.sv
// Checker of the APB answer of the gain normalization command unit.
// Assumes the gncu_top ports and the offsets of gncu_map.svh.
`include "gncu_map.svh"
`timescale 1ns/1ps
`default_nettype none

module gncu_props
(
  input wire logic        mclk,
  input wire logic        sys_rst,
  input wire logic        memOptionFitted,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (sys_rst);

  sequence setupSeq;
    psel && !penable;
  endsequence
  sequence accessTo(cond);
    psel && penable && !pready && cond;
  endsequence

  a_ready_wait: assert property (setupSeq ##1 accessTo(1'b1) |=> pready)
    else $error("pready not one cycle after access");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready held too long");
  a_ready_cause: assert property (pready |-> $past(psel && penable))
    else $error("pready without access");
  a_err_paired: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_write_zero: assert property (pready && pwrite |-> prdata == 32'h0)
    else $error("prdata not zero on write");
  a_error_zero: assert property (pslverr |-> prdata == 32'h0)
    else $error("prdata not zero on error");
  a_reset_quiet: assert property ($fell(sys_rst) |-> !pready && !pslverr && prdata == 32'h0)
    else $error("outputs active after reset");
  a_unmapped_err: assert property (accessTo(paddr > `GNCU_ADDR_RGAIN) |=> pslverr)
    else $error("unmapped access not refused");
  a_readonly_err: assert property (accessTo(pwrite && paddr >= `GNCU_ADDR_STATUS) |=> pslverr)
    else $error("write to read-only not refused");
  a_cmd_read_err: assert property (accessTo(!pwrite && paddr == `GNCU_ADDR_CMD) |=> pslverr)
    else $error("command read not refused");
  a_status_ok: assert property (accessTo(!pwrite && paddr == `GNCU_ADDR_STATUS) |=> !pslverr)
    else $error("status read refused");
endmodule

bind gncu_top gncu_props u_gncu_props
(
  .mclk            (mclk),
  .sys_rst         (sys_rst),
  .memOptionFitted (memOptionFitted),
  .psel            (psel),
  .penable         (penable),
  .pwrite          (pwrite),
  .paddr           (paddr),
  .pwdata          (pwdata),
  .prdata          (prdata),
  .pready          (pready),
  .pslverr         (pslverr)
);
`default_nettype wire

// File: bench/gncu_host_model.sv
// Host side: an APB master that issues the parsed commands.
// Assumes gncu_top answers each access with pready.
`include "gncu_map.svh"
`timescale 1ns/1ps
`default_nettype none

module gncu_host_model
(
  input  wire logic        mclk,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [7:0]       paddr,
  output logic [31:0]      pwdata
);
  initial
  begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
  end

  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic err);
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do
      @(posedge mclk);
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Released lines do not keep their last value
    paddr <= ~a;
    pwdata <= ~d;
  endtask

  task automatic command(input logic [2:0] op, input logic [4:0] ch, input logic [13:0] val,
                         output logic err);
    logic [31:0] rd;
    xfer(1'b1, `GNCU_ADDR_CMD, {1'b0, op, 7'h0, ch, 2'h0, val}, rd, err);
  endtask
endmodule
`default_nettype wire

// File: bench/gncu_top_tb.sv
// Self-checking bench of the gain normalization command unit.
// Assumes gncu_host_model as the APB master and a software model here.
`include "gncu_map.svh"
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) \
  begin \
    check_count++; \
    if ((g) !== (e)) \
    begin \
      err_count++; \
      $display("[FAIL] %0t got %h want %h", $time, (g), (e)); \
    end \
  end

module gncu_top_tb;
  logic        mclk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        memOptionFitted = 1'b0;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  int          err_count = 0;
  int          check_count = 0;
  int          cyc = 0;
  integer      seed = 32'h84515361;
  logic [13:0] mSens [1:16];
  logic [13:0] mExp [1:16];
  logic [3:0]  mLevel;
  logic        ext;
  logic [31:0] rd;
  logic        err;
  logic [2:0]  res;
  int          r;
  logic [2:0]  op;
  logic [4:0]  ch;
  localparam logic [21:0] CORNER [12] = '{{3'h1, 5'h00, 14'h5}, {3'h1, 5'h00, 14'hb},
    {3'h1, 5'h00, 14'h0}, {3'h1, 5'h11, 14'h64}, {3'h2, 5'h00, 14'h3}, {3'h0, 5'h01, 14'h1},
    {3'h5, 5'h01, 14'h1}, {3'h1, 5'h03, 14'h0}, {3'h2, 5'h04, 14'h0}, {3'h1, 5'h02, 14'h2710},
    {3'h3, 5'h00, 14'h0}, {3'h1, 5'h00, 14'h1}};

  always #5 mclk = ~mclk;

  gncu_top u_gncu_top (.mclk(mclk), .sys_rst(sys_rst), .memOptionFitted(memOptionFitted),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr));
  gncu_host_model u_host (.mclk(mclk), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));

  function automatic logic [29:0] calc(input logic [3:0] lv, input logic [13:0] s,
                                       input logic [13:0] e);
    longint unsigned den;
    den = longint'(s) * longint'(e);
    if (den == 0)
      return 30'h3fffffff;
    return 30'(longint'(lv) * 64'd100000000 / den);
  endfunction

  function automatic bit inRange(input logic [29:0] g);
    return g >= (ext ? `GNCU_GAIN_MIN_EXT : `GNCU_GAIN_MIN_STD) && g <= `GNCU_GAIN_MAX;
  endfunction

  task automatic finish_test();
    if (err_count == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic rdChk(input logic [7:0] a, input logic [31:0] want, input logic wantErr);
    u_host.xfer(1'b0, a, 32'h0, rd, err);
    `CHK(rd, want)
    `CHK(err, wantErr)
  endtask

  task automatic setExt(input logic v);
    ext = v;
    u_host.xfer(1'b1, `GNCU_ADDR_CONFIG, {31'h0, v}, rd, err);
  endtask

  // Command with expected result; hit adds a write while busy
  task automatic run(input logic [2:0] op, input logic [4:0] ch, input logic [13:0] val,
                     input bit hit);
    logic [2:0]  want;
    bit          good;
    logic [13:0] s;
    logic [13:0] e;
    good = 1;
    want = 3'h3;
    if (op == 3'h1 && ch == 5'h0)
    begin
      want = 3'h2;
      if (val >= `GNCU_LEVEL_MIN && val <= `GNCU_LEVEL_MAX)
      begin
        for (int c = 1; c <= 16; c++)
          good &= inRange(calc(val[3:0], mSens[c], mExp[c]));
        want = good ? 3'h1 : 3'h2;
        if (good)
          mLevel = val[3:0];
      end
    end
    else if ((op == 3'h1 || op == 3'h2) && ch >= 5'h1 && ch <= `GNCU_LAST_CHAN)
    begin
      s = (op == 3'h1) ? val : mSens[ch];
      e = (op == 3'h2) ? val : mExp[ch];
      want = (val <= `GNCU_VALUE_MAX && inRange(calc(mLevel, s, e))) ? 3'h1 : 3'h2;
      if (want == 3'h1)
      begin
        mSens[ch] = s;
        mExp[ch] = e;
      end
    end
    else if ((op == 3'h3 && ch <= `GNCU_LAST_CHAN) || (op == 3'h4 && ch >= 5'h1 &&
             ch <= `GNCU_LAST_CHAN))
      want = 3'h4;
    u_host.command(op, ch, val, err);
    `CHK(err, 1'b0)
    if (hit)
    begin
      u_host.command(3'h2, 5'h1, 14'h7, err);
      `CHK(err, 1'b1)
    end
    do
      u_host.xfer(1'b0, `GNCU_ADDR_STATUS, 32'h0, rd, err);
    while (rd[`GNCU_STAT_BUSY] !== 1'b0);
    res = rd[`GNCU_STAT_RES_MSB:`GNCU_STAT_RES_LSB];
    `CHK(res, want)
  endtask

  task automatic qry(input logic [4:0] ch);
    run(3'h3, ch, 14'h0, 0);
    rdChk(`GNCU_ADDR_RSENS, {18'h0, mSens[ch]}, 1'b0);
    rdChk(`GNCU_ADDR_RLEVEL, {28'h0, mLevel}, 1'b0);
    rdChk(`GNCU_ADDR_REXPECT, {18'h0, mExp[ch]}, 1'b0);
    rdChk(`GNCU_ADDR_RGAIN, {11'h0, 21'(calc(mLevel, mSens[ch], mExp[ch]))}, 1'b0);
  endtask

  task automatic resetDut(input logic fit);
    memOptionFitted <= fit;
    sys_rst <= 1'b1;
    repeat (4) @(posedge mclk);
    sys_rst <= 1'b0;
    repeat (30) @(posedge mclk);
    setExt(1'b0);
    if (!fit)
    begin
      mLevel = `GNCU_DEF_LEVEL;
      for (int c = 1; c <= 16; c++)
      begin
        mSens[c] = `GNCU_DEF_SENS;
        mExp[c] = `GNCU_DEF_EXPECT;
      end
    end
    for (int c = 1; c <= 16; c++)
      qry(5'(c));
  endtask

  always @(posedge mclk)
  begin
    cyc++;
    if (cyc == 90000)
    begin
      err_count++;
      finish_test();
    end
  end

  initial
  begin
    resetDut(1'b0);
    foreach (CORNER[i])
      run(CORNER[i][21:19], CORNER[i][18:14], CORNER[i][13:0], i == 0);
    run(3'h1, 5'h5, 14'h270f, 0);
    run(3'h2, 5'h5, 14'hc8, 0);
    setExt(1'b1);
    run(3'h2, 5'h5, 14'hc8, 0);
    qry(5'h5);
    rdChk(`GNCU_ADDR_CONFIG, 32'h1, 1'b0);
    rdChk(8'h1c, 32'h0, 1'b1);
    rdChk(`GNCU_ADDR_CMD, 32'h0, 1'b1);
    u_host.xfer(1'b1, `GNCU_ADDR_STATUS, 32'h1, rd, err);
    `CHK(err, 1'b1)
    for (int i = 0; i < 80; i++)
    begin
      if (i % 8 == 0)
        setExt(1'($random(seed)));
      r = $random(seed) & 32'h7fffffff;
      op = 3'(r % 4 + 1);
      ch = 5'((r >> 4) % 17);
      r = $random(seed) & 32'h7fffffff;
      run(op, ch, 14'((op == 3'h1 && ch == 5'h0) ? r % 11 : (op == 3'h1) ? r % 10000 : r % 40),
          0);
      if (ch != 5'h0)
        qry(ch);
    end
    resetDut(1'b1);
    resetDut(1'b0);
    finish_test();
  end
endmodule
`default_nettype wire
